// *** ppb_board_model.sv ***
// Board model: memory and reset button on the far side of the port pins
`timescale 1ns/1ps
module ppb_board_model (
  input wire logic [15:0] data_o_i,   // Data port drive value
  input wire logic [15:0] data_oe_i,  // Data port enables
  input wire logic [15:0] addr_i,     // Address port wires
  input wire logic mem_rd_i,          // Memory output enable
  input wire logic rst_oe_i,          // Reset pin pull-down enable
  input wire logic ext_rst_n_i,       // Reset button, low = pressed
  output logic [15:0] data_pin_o,     // Resolved data port wires
  output logic rst_pin_o              // Resolved reset wire
);
  logic [15:0] mem_q;
  // Content is a fixed function of the address so the bench can predict it
  assign mem_q = {addr_i[7:0], ~addr_i[7:0]};
  // Released lines read memory while mem_rd_i is high, else the board pull-ups; never the last driven value
  assign data_pin_o = (data_oe_i & data_o_i) | (~data_oe_i & (mem_rd_i ? mem_q : 16'hffff));
  // Open drain with pull-up; the bench holds the button across the synchroniser
  assign rst_pin_o = ~rst_oe_i & ext_rst_n_i;
endmodule

// *** ppb_pin_bank.sv ***
// Pin bank: input synchroniser plus driver selection for one port
`timescale 1ns/1ps
module ppb_pin_bank #(
  parameter int W = 16
) (
  input wire logic sys_clk_i,          // System clock
  input wire logic rst_i,              // Synchronous reset
  input wire logic [W-1:0] pin_i,      // Pin levels from pads
  input wire logic [W-1:0] out_val_i,  // Port output latch
  input wire logic [W-1:0] dir_i,      // 1 = output
  input wire logic [W-1:0] od_i,       // 1 = open drain
  input wire logic [W-1:0] claim_i,    // Bus owns pin
  input wire logic [W-1:0] bus_out_i,  // Bus drive value
  input wire logic [W-1:0] bus_oe_i,   // Bus drive enable
  output logic [W-1:0] pin_o,          // Pad output value
  output logic [W-1:0] pin_oe_o,       // Pad output enable
  output logic [W-1:0] sync_o          // Synchronised pin level
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } ppb_sync_t;
  ppb_sync_t st;
  ppb_sync_t next_st;

  always_comb begin
    next_st.s1 = pin_i;
    next_st.s2 = st.s1;
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign sync_o = st.s2;
  // Bus ownership replaces the direction bits entirely
  // Input pins float; open drain never drives high
  assign pin_o = (claim_i & bus_out_i) | (~claim_i & out_val_i);
  assign pin_oe_o = (claim_i & bus_oe_i) | (~claim_i & dir_i & ~(od_i & out_val_i));

  od_low_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    ((~claim_i & od_i & pin_oe_o & pin_o) == '0))
    else $error("open drain pin driven high");
endmodule

// *** ppb_pkg.sv ***
// Constants, register map and types shared by the port pin block
package ppb_pkg;
  localparam int NPORT = 6;
  localparam int PIDX_DATA = 0;
  localparam int PIDX_ADDR = 1;
  localparam int PIDX_P3 = 2;
  localparam int PIDX_P6 = 3;
  localparam int PIDX_P2 = 4;
  localparam int PIDX_P7 = 5;
  localparam int ADDR_W = 8;
  // Address layout: [6:4] port index, [1:0] field
  localparam logic [1:0] FLD_OUT = 2'h0;
  localparam logic [1:0] FLD_DIR = 2'h1;
  localparam logic [1:0] FLD_OD = 2'h2;
  localparam logic [1:0] FLD_IN = 2'h3;
  localparam logic [2:0] GRP_P5 = 3'h6;
  localparam logic [2:0] GRP_CTRL = 3'h7;
  localparam logic [7:0] OFS_BUS_CFG = 8'h70;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h71;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h72;
  localparam logic [7:0] OFS_RST_CTRL = 8'h73;
  localparam logic [7:0] OFS_P5_IN = 8'h63;
  // bus_config_reg fields
  localparam int CFG_EXT_EN = 0;
  localparam int CFG_MUX = 1;
  localparam int CFG_W16 = 2;
  localparam int CFG_ANY_DEMUX = 3;
  localparam int CFG_PWM3 = 4;
  localparam logic [4:0] CFG_RST = 5'h00;
  // Interrupt status fields
  localparam int ST_NMI = 0;
  localparam int ST_FX0 = 1;
  localparam logic [4:0] STAT_RST = 5'h00;
  localparam logic [15:0] PORT_RST = 16'h0000;
  // Implemented pins per port; bit 14 of port 3 has no pin
  localparam logic [15:0] MASK_DATA = 16'hffff;
  localparam logic [15:0] MASK_ADDR = 16'hffff;
  localparam logic [15:0] MASK_P3 = 16'hbfff;
  localparam logic [15:0] MASK_P6 = 16'h00ff;
  localparam logic [15:0] MASK_NIB = 16'h000f;
  localparam int MISSING_BIT14 = 14;
  localparam int PWM_BIT = 3;
  localparam int RST_DRIVE_CYCLES = 512;
  localparam int RST_CNT_W = 10;
  localparam logic [2:0] RST_HOLDOFF_CYCLES = 3'h4;
  localparam int WAKE_CNT_W = 16;
  typedef enum logic [1:0] {PM_RUN, PM_DOWN, PM_WAKE} ppb_pm_t;
endpackage

// *** ppb_port_pins.sv ***
// Port pins with external bus overlay, reset pin, NMI and wake control
//
// Chosen here: the register addresses and the plain strobed port.
`timescale 1ns/1ps
module ppb_port_pins import ppb_pkg::*; #(
  parameter logic [WAKE_CNT_W-1:0] WAKE_DELAY_CYCLES = 16'h0400
) (
  input wire logic sys_clk_i,                 // System clock, 100 MHz
  input wire logic rst_i,                     // Synchronous reset
  input wire logic [ADDR_W-1:0] reg_addr_i,   // Register address
  input wire logic [15:0] reg_wdata_i,        // Register write data
  input wire logic reg_wr_i,                  // Write strobe
  input wire logic reg_rd_i,                  // Read strobe
  output logic [15:0] reg_rdata_o,            // Read data, cycle after strobe
  input wire logic [15:0] bus_addr_i,         // External bus address
  input wire logic [15:0] bus_wdata_i,        // External bus write data
  input wire logic bus_addr_phase_i,          // Mux address phase
  input wire logic bus_data_oe_i,             // Drive data phase
  output logic [15:0] bus_rdata_o,            // Synchronised data port
  input wire logic [15:0] bus_data_port_i,    // Data port pins in
  output logic [15:0] bus_data_port_o,        // Data port pins out
  output logic [15:0] bus_data_port_oe_o,     // Data port enables
  input wire logic [15:0] bus_address_port_i, // Address port pins in
  output logic [15:0] bus_address_port_o,     // Address port pins out
  output logic [15:0] bus_address_port_oe_o,  // Address port enables
  input wire logic [15:0] port3_i,            // Port 3 pins in
  output logic [15:0] port3_o,                // Port 3 pins out
  output logic [15:0] port3_oe_o,             // Port 3 enables
  input wire logic [7:0] port6_i,             // Port 6 pins in
  output logic [7:0] port6_o,                 // Port 6 pins out
  output logic [7:0] port6_oe_o,              // Port 6 enables
  input wire logic [3:0] port2_i,             // Port 2 pins 8..11 in
  output logic [3:0] port2_o,                 // Port 2 pins out
  output logic [3:0] port2_oe_o,              // Port 2 enables
  input wire logic [3:0] port7_i,             // Port 7 pins in
  output logic [3:0] port7_o,                 // Port 7 pins out
  output logic [3:0] port7_oe_o,              // Port 7 enables
  input wire logic [5:0] port5_i,             // Input-only port pins
  output logic [5:0] timer_in_o,              // Port 5 levels to timers
  input wire logic pwm_ch3_out_i,             // PWM channel 3 level
  input wire logic reset_in_n_i,              // Reset pin level
  output logic reset_in_n_o,                  // Reset pin drive value
  output logic reset_in_n_oe_o,               // Reset pin pull-down enable
  output logic reset_indication_n_o,          // Reset indication pin
  output logic chip_reset_o,                  // Reset to rest of chip
  input wire logic sw_reset_i,                // Software reset pulse
  input wire logic wdt_reset_i,               // Watchdog reset pulse
  input wire logic end_of_init_instr_i,       // End-of-init executed
  input wire logic nmi_n_i,                   // Non-maskable interrupt pin
  output logic nmi_trap_o,                    // NMI trap request pulse
  output logic [3:0] fast_ext_irq_o,          // Fast interrupt pulses
  input wire logic power_down_req_i,          // Enter power-down pulse
  output logic cpu_clk_en_o,                  // Clock enable to CPU
  output logic irq_o                          // Level interrupt
);
  typedef struct packed {
    logic [NPORT-1:0][15:0] out;
    logic [NPORT-1:0][15:0] dir;
    logic [NPORT-1:0][15:0] od;
    logic [4:0] cfg;
    logic [4:0] stat;
    logic [4:0] mask;
    logic [15:0] rdata;
    logic rst_drv;
    logic [RST_CNT_W-1:0] rst_cnt;
    logic [2:0] holdoff;
    logic ind_n;
    logic nmi_q;
    logic [3:0] fx_q;
    ppb_pm_t pm;
    logic [WAKE_CNT_W-1:0] wake_cnt;
    logic [10:0] drv_len;
  } ppb_state_t;

  ppb_state_t st;
  ppb_state_t next_st;

  function automatic logic [15:0] port_mask(input int idx);
    case (idx)
      PIDX_DATA: port_mask = MASK_DATA;
      PIDX_ADDR: port_mask = MASK_ADDR;
      PIDX_P3: port_mask = MASK_P3;
      PIDX_P6: port_mask = MASK_P6;
      default: port_mask = MASK_NIB;
    endcase
  endfunction

  // Only ports 3, 6, 2 and 7 have open-drain capability
  function automatic logic [15:0] od_mask(input int idx);
    od_mask = (idx == PIDX_DATA || idx == PIDX_ADDR) ? 16'h0000 : port_mask(idx);
  endfunction

  logic [NPORT-1:0][15:0] pin_in;
  logic [NPORT-1:0][15:0] pin_out;
  logic [NPORT-1:0][15:0] pin_oe;
  logic [NPORT-1:0][15:0] pin_sync;
  logic [NPORT-1:0][15:0] out_val;
  logic [NPORT-1:0][15:0] claim;
  logic [NPORT-1:0][15:0] bus_out;
  logic [NPORT-1:0][15:0] bus_oe;
  logic [5:0] p5_sync;
  logic [1:0] misc_sync;
  logic [1:0] misc_o;
  logic [1:0] misc_oe;
  logic ext;
  logic mux;
  logic w16;
  logic lo_addr;
  logic hi_addr;
  logic nmi_fall;
  logic [3:0] fx_fall;
  logic rst_pin_low;
  logic trigger;
  logic [15:0] rd_val;

  assign pin_in[PIDX_DATA] = bus_data_port_i;
  assign pin_in[PIDX_ADDR] = bus_address_port_i;
  assign pin_in[PIDX_P3] = port3_i;
  assign pin_in[PIDX_P6] = {8'h00, port6_i};
  assign pin_in[PIDX_P2] = {12'h000, port2_i};
  assign pin_in[PIDX_P7] = {12'h000, port7_i};

  // External bus overlay on the data and address ports
  assign ext = st.cfg[CFG_EXT_EN];
  assign mux = st.cfg[CFG_MUX];
  assign w16 = st.cfg[CFG_W16];
  assign lo_addr = mux & bus_addr_phase_i;
  assign hi_addr = mux & (~w16 | bus_addr_phase_i);

  always_comb begin
    claim = '0;
    bus_out = '0;
    bus_oe = '0;
    out_val = st.out;
    if (ext) begin
      // High byte stays general I/O only for 8-bit demultiplexed
      claim[PIDX_DATA] = {(w16 | mux) ? 8'hff : 8'h00, 8'hff};
      bus_out[PIDX_DATA][7:0] = lo_addr ? bus_addr_i[7:0] : bus_wdata_i[7:0];
      bus_out[PIDX_DATA][15:8] = hi_addr ? bus_addr_i[15:8] : bus_wdata_i[15:8];
      bus_oe[PIDX_DATA] = {{8{hi_addr | bus_data_oe_i}}, {8{lo_addr | bus_data_oe_i}}};
      if (~mux | st.cfg[CFG_ANY_DEMUX]) begin
        claim[PIDX_ADDR] = 16'hffff;
        bus_out[PIDX_ADDR] = bus_addr_i;
        bus_oe[PIDX_ADDR] = 16'hffff;
      end
    end
    if (st.cfg[CFG_PWM3]) begin
      out_val[PIDX_P7][PWM_BIT] = pwm_ch3_out_i;
    end
  end

  for (genvar g = 0; g < NPORT; g++) begin : g_bank
    ppb_pin_bank #(.W(16)) u_bank (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .pin_i(pin_in[g]),
      .out_val_i(out_val[g]),
      .dir_i(st.dir[g]),
      .od_i(st.od[g]),
      .claim_i(claim[g]),
      .bus_out_i(bus_out[g]),
      .bus_oe_i(bus_oe[g]),
      .pin_o(pin_out[g]),
      .pin_oe_o(pin_oe[g]),
      .sync_o(pin_sync[g])
    );
  end

  // Input-only port: never enabled, so no driver exists
  ppb_pin_bank #(.W(6)) u_p5 (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .pin_i(port5_i),
    .out_val_i(6'h00),
    .dir_i(6'h00),
    .od_i(6'h00),
    .claim_i(6'h00),
    .bus_out_i(6'h00),
    .bus_oe_i(6'h00),
    .pin_o(),
    .pin_oe_o(),
    .sync_o(p5_sync)
  );

  // Bit 0 is the reset pin, open drain pulled low while driving; bit 1 is NMI
  ppb_pin_bank #(.W(2)) u_misc (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .pin_i({nmi_n_i, reset_in_n_i}),
    .out_val_i({1'b1, ~st.rst_drv}),
    .dir_i(2'b01),
    .od_i(2'b01),
    .claim_i(2'b00),
    .bus_out_i(2'b00),
    .bus_oe_i(2'b00),
    .pin_o(misc_o),
    .pin_oe_o(misc_oe),
    .sync_o(misc_sync)
  );

  assign nmi_fall = st.nmi_q & ~misc_sync[1];
  // Port 2 slice index 0..3 is pin 8..11, interrupt 0..3
  assign fx_fall = st.fx_q & ~pin_sync[PIDX_P2][3:0];
  // Our own pull-down echoes back late; the hold-off hides it
  assign rst_pin_low = ~misc_sync[0] & ~st.rst_drv & (st.holdoff == 3'h0);
  assign trigger = rst_pin_low | sw_reset_i | wdt_reset_i;

  always_comb begin
    rd_val = 16'h0000;
    if (reg_addr_i[6:4] < 3'(NPORT) && reg_addr_i[7] == 1'b0) begin
      case (reg_addr_i[1:0])
        FLD_OUT: rd_val = st.out[reg_addr_i[6:4]];
        FLD_DIR: rd_val = st.dir[reg_addr_i[6:4]];
        FLD_OD: rd_val = st.od[reg_addr_i[6:4]];
        default: rd_val = pin_sync[reg_addr_i[6:4]] & port_mask(int'(reg_addr_i[6:4]));
      endcase
      if (reg_addr_i[3:2] != 2'h0) begin
        rd_val = 16'h0000;
      end
    end else begin
      case (reg_addr_i)
        OFS_P5_IN: rd_val = {10'h000, p5_sync};
        OFS_BUS_CFG: rd_val = {11'h000, st.cfg};
        OFS_IRQ_STAT: rd_val = {11'h000, st.stat};
        OFS_IRQ_MASK: rd_val = {11'h000, st.mask};
        OFS_RST_CTRL: rd_val = {14'h0000, st.rst_drv, st.ind_n};
        default: rd_val = 16'h0000;
      endcase
    end
  end

  always_comb begin
    next_st = st;
    next_st.nmi_q = misc_sync[1];
    next_st.fx_q = pin_sync[PIDX_P2][3:0];
    next_st.rdata = reg_rd_i ? rd_val : st.rdata;
    if (st.holdoff != 3'h0) begin
      next_st.holdoff = st.holdoff - 3'h1;
    end
    if (reg_wr_i) begin
      for (int p = 0; p < NPORT; p++) begin
        if (reg_addr_i == {1'b0, 3'(p), 2'h0, FLD_OUT}) begin
          next_st.out[p] = reg_wdata_i & port_mask(p);
        end
        if (reg_addr_i == {1'b0, 3'(p), 2'h0, FLD_DIR}) begin
          next_st.dir[p] = reg_wdata_i & port_mask(p);
        end
        if (reg_addr_i == {1'b0, 3'(p), 2'h0, FLD_OD}) begin
          next_st.od[p] = reg_wdata_i & od_mask(p);
        end
      end
      case (reg_addr_i)
        OFS_BUS_CFG: next_st.cfg = reg_wdata_i[4:0];
        OFS_IRQ_STAT: next_st.stat = st.stat & ~reg_wdata_i[4:0];
        OFS_IRQ_MASK: next_st.mask = reg_wdata_i[4:0];
        default: next_st.cfg = next_st.cfg;
      endcase
    end
    // Set wins over a write-one-to-clear in the same cycle
    next_st.stat = next_st.stat | {fx_fall, nmi_fall};
    // Reset drive counter and reset indication
    if (st.rst_drv) begin
      next_st.drv_len = st.drv_len + 11'h001;
      if (st.rst_cnt == '0) begin
        next_st.rst_drv = 1'b0;
        next_st.holdoff = RST_HOLDOFF_CYCLES;
      end else begin
        next_st.rst_cnt = st.rst_cnt - 1'b1;
      end
    end else if (end_of_init_instr_i) begin
      next_st.ind_n = 1'b1;
    end
    if (trigger && !st.rst_drv) begin
      // Any reset source restores the port setup and starts the pull-down
      next_st.out = '0;
      next_st.dir = '0;
      next_st.od = '0;
      next_st.cfg = CFG_RST;
      next_st.stat = STAT_RST;
      next_st.mask = STAT_RST;
      next_st.rst_drv = 1'b1;
      next_st.rst_cnt = RST_CNT_W'(RST_DRIVE_CYCLES - 1);
      next_st.drv_len = 11'h001;
      next_st.ind_n = 1'b0;
      next_st.pm = PM_RUN;
    end else begin
      unique case (st.pm)
        PM_RUN: begin
          if (power_down_req_i) begin
            next_st.pm = PM_DOWN;
          end
        end
        PM_DOWN: begin
          if (fx_fall != 4'h0) begin
            next_st.pm = PM_WAKE;
            next_st.wake_cnt = WAKE_DELAY_CYCLES - 1'b1;
          end
        end
        PM_WAKE: begin
          if (st.wake_cnt == '0) begin
            next_st.pm = PM_RUN;
          end else begin
            next_st.wake_cnt = st.wake_cnt - 1'b1;
          end
        end
        default: next_st.pm = PM_RUN;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      st <= '0;
      // Synchronisers restart at zero, so edge history does too; the hold-off
      // masks the reset pin until the synchroniser holds the real level
      st.holdoff <= RST_HOLDOFF_CYCLES;
      st.pm <= PM_RUN;
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata_o = st.rdata;
  assign bus_rdata_o = pin_sync[PIDX_DATA];
  assign bus_data_port_o = pin_out[PIDX_DATA];
  assign bus_data_port_oe_o = pin_oe[PIDX_DATA];
  assign bus_address_port_o = pin_out[PIDX_ADDR];
  assign bus_address_port_oe_o = pin_oe[PIDX_ADDR];
  assign port3_o = pin_out[PIDX_P3];
  assign port3_oe_o = pin_oe[PIDX_P3];
  assign port6_o = pin_out[PIDX_P6][7:0];
  assign port6_oe_o = pin_oe[PIDX_P6][7:0];
  assign port2_o = pin_out[PIDX_P2][3:0];
  assign port2_oe_o = pin_oe[PIDX_P2][3:0];
  assign port7_o = pin_out[PIDX_P7][3:0];
  assign port7_oe_o = pin_oe[PIDX_P7][3:0];
  assign timer_in_o = p5_sync;
  assign reset_in_n_o = misc_o[0];
  assign reset_in_n_oe_o = misc_oe[0];
  assign reset_indication_n_o = st.ind_n;
  assign chip_reset_o = st.rst_drv | ~misc_sync[0];
  assign nmi_trap_o = nmi_fall;
  assign fast_ext_irq_o = fx_fall;
  assign cpu_clk_en_o = (st.pm == PM_RUN);
  assign irq_o = |(st.stat & st.mask);

  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  rst_len_a: assert property ($fell(st.rst_drv) |-> $past(st.drv_len) == 11'd512)
    else $error("reset pull-down length not 512");
  rst_pin_a: assert property (st.rst_drv |-> reset_in_n_oe_o && !reset_in_n_o)
    else $error("reset pin not pulled low");
  ind_hold_a: assert property (!st.ind_n && !end_of_init_instr_i |=> !st.ind_n)
    else $error("reset indication rose without end of init");
  ext_rst_a: assert property (rst_pin_low && !st.rst_drv |=> st.rst_drv)
    else $error("external reset not taken");
  nmi_stat_a: assert property (nmi_fall |=> st.stat[ST_NMI])
    else $error("nmi edge lost");
  fx_stat_a: assert property (fx_fall[0] |=> st.stat[ST_FX0])
    else $error("fast interrupt edge lost");
  demux_hi_a: assert property (ext && !mux && !w16 |-> claim[PIDX_DATA][15:8] == 8'h00)
    else $error("high byte claimed in 8-bit demux");
  mux_hi_a: assert property (ext && mux && !w16 |->
    bus_data_port_oe_o[15:8] == 8'hff && bus_data_port_o[15:8] == bus_addr_i[15:8])
    else $error("high byte not carrying address");
  data_bus_a: assert property (ext && !mux && bus_data_oe_i |->
    bus_data_port_o[7:0] == bus_wdata_i[7:0] && &bus_data_port_oe_o[7:0])
    else $error("data port not carrying data");
  addr_port_a: assert property (ext && (!mux || st.cfg[CFG_ANY_DEMUX]) |->
    bus_address_port_oe_o == 16'hffff && bus_address_port_o == bus_addr_i)
    else $error("address port not driving address");
  input_hiz_a: assert property ((~st.dir[PIDX_P6][7:0] & port6_oe_o) == 8'h00)
    else $error("input pin driven");
  bit14_a: assert property (!port3_oe_o[MISSING_BIT14])
    else $error("missing pin driven");
  pwm_out_a: assert property (st.cfg[CFG_PWM3] && port7_oe_o[PWM_BIT] |->
    port7_o[PWM_BIT] == pwm_ch3_out_i)
    else $error("pwm not on port 7 bit 3");
  wake_hold_a: assert property ($rose(st.pm == PM_WAKE) |->
    !cpu_clk_en_o [*8])
    else $error("clock released during wake delay");

  rst_c: cover property ($fell(st.rst_drv));
  wake_c: cover property (st.pm == PM_WAKE ##1 st.pm == PM_RUN);
  nmi_c: cover property (nmi_fall ##1 irq_o);
  mux_c: cover property (ext && mux && bus_addr_phase_i ##1 bus_data_oe_i);
endmodule

// *** tb.sv ***
// Self-checking bench for the port pin block
`timescale 1ns/1ps
module tb;
  import ppb_pkg::*;
  localparam logic [15:0] WAKE = 16'h000a;
  logic sys_clk_i, rst_i, reg_wr_i, reg_rd_i, bus_addr_phase_i, bus_data_oe_i, mem_rd;
  logic [7:0] reg_addr_i, port6_i, port6_o, port6_oe_o;
  logic [15:0] reg_wdata_i, reg_rdata_o, bus_addr_i, bus_wdata_i, bus_rdata_o, port3_i, port3_o;
  logic [15:0] bus_data_port_i, bus_data_port_o, bus_data_port_oe_o, port3_oe_o;
  logic [15:0] bus_address_port_i, bus_address_port_o, bus_address_port_oe_o;
  logic [3:0] port2_i, port2_o, port2_oe_o, port7_i, port7_o, port7_oe_o, fast_ext_irq_o, p2_ext;
  logic [5:0] port5_i, timer_in_o;
  logic pwm_ch3_out_i, reset_in_n_i, reset_in_n_o, reset_in_n_oe_o, reset_indication_n_o;
  logic chip_reset_o, sw_reset_i, wdt_reset_i, end_of_init_instr_i, nmi_n_i, nmi_trap_o;
  logic power_down_req_i, cpu_clk_en_o, irq_o, ext_rst_n;
  int error_cnt = 0;
  int samples_checked = 0;
  int cyc = 0;
  // Undriven pins read high through board pull-ups, except port 2, which reads p2_ext, and the data port, which reads memory while mem_rd is high
  assign port3_i = port3_o | ~port3_oe_o;
  assign port6_i = port6_o | ~port6_oe_o;
  assign port7_i = port7_o | ~port7_oe_o;
  assign port2_i = (port2_oe_o & port2_o) | (~port2_oe_o & p2_ext);
  assign bus_address_port_i = bus_address_port_o | ~bus_address_port_oe_o;
  ppb_port_pins #(.WAKE_DELAY_CYCLES(WAKE)) u_dut (.sys_clk_i, .rst_i, .reg_addr_i,
    .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .bus_addr_i, .bus_wdata_i,
    .bus_addr_phase_i, .bus_data_oe_i, .bus_rdata_o, .bus_data_port_i, .bus_data_port_o,
    .bus_data_port_oe_o, .bus_address_port_i, .bus_address_port_o, .bus_address_port_oe_o,
    .port3_i, .port3_o, .port3_oe_o, .port6_i, .port6_o, .port6_oe_o, .port2_i, .port2_o,
    .port2_oe_o, .port7_i, .port7_o, .port7_oe_o, .port5_i, .timer_in_o, .pwm_ch3_out_i,
    .reset_in_n_i, .reset_in_n_o, .reset_in_n_oe_o, .reset_indication_n_o, .chip_reset_o,
    .sw_reset_i, .wdt_reset_i, .end_of_init_instr_i, .nmi_n_i, .nmi_trap_o, .fast_ext_irq_o,
    .power_down_req_i, .cpu_clk_en_o, .irq_o);
  ppb_board_model u_board (.data_o_i(bus_data_port_o), .data_oe_i(bus_data_port_oe_o),
    .addr_i(bus_address_port_i), .mem_rd_i(mem_rd), .rst_oe_i(reset_in_n_oe_o),
    .ext_rst_n_i(ext_rst_n), .data_pin_o(bus_data_port_i), .rst_pin_o(reset_in_n_i));
  task automatic close_out();
    if (error_cnt == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    #1 chk(reg_rdata_o, exp);
  endtask
  task automatic end_init();
    @(posedge sys_clk_i);
    end_of_init_instr_i <= 1'b1;
    @(posedge sys_clk_i);
    end_of_init_instr_i <= 1'b0;
    tick(1);
  endtask
  task automatic t_gpio();
    wr(8'h20, 16'h0f0f);
    wr(8'h21, 16'hffff);
    tick(1);
    chk(port3_oe_o, MASK_P3);
    chk(port3_o & MASK_P3, 16'h0f0f);
    wr(8'h22, 16'hffff);
    tick(4);
    chk(port3_oe_o, 16'hb0f0);
    chk(port3_o & port3_oe_o, 16'h0000);
    rd_chk(8'h23, 16'h0f0f);
    wr(8'h21, 16'h0000);
    tick(1);
    chk(port3_oe_o, 16'h0000);
    wr(8'h40, 16'h000f);
    wr(8'h41, 16'h001f);
    wr(8'h31, 16'h01ff);
    tick(1);
    chk({8'h0, port2_oe_o, port2_o}, 16'h00ff);
    chk({port6_oe_o, port6_o}, 16'hff00);
    wr(8'h41, 16'h0000);
    @(posedge sys_clk_i);
    port5_i <= 6'h2a;
    tick(4);
    chk({10'h0, timer_in_o}, 16'h002a);
    rd_chk(OFS_P5_IN, 16'h002a);
  endtask
  task automatic bus_case(input logic [15:0] cfg, input logic ph, input logic doe,
      input logic [15:0] m, input logic [15:0] o, input logic [15:0] oe, input logic [15:0] aoe);
    wr(OFS_BUS_CFG, cfg);
    @(posedge sys_clk_i);
    bus_addr_phase_i <= ph;
    bus_data_oe_i <= doe;
    tick(1);
    chk(bus_data_port_oe_o & m, oe);
    chk(bus_data_port_o & oe, o);
    chk(bus_address_port_oe_o, aoe);
    chk(bus_address_port_o & aoe, 16'h1234 & aoe);
  endtask
  task automatic t_irq();
    int k;
    wr(OFS_IRQ_MASK, 16'h001f);
    @(posedge sys_clk_i);
    nmi_n_i <= 1'b0;
    for (k = 0; k < 8 && nmi_trap_o !== 1'b1; k++) tick(1);
    chk({15'h0, nmi_trap_o}, 16'h0001);
    @(posedge sys_clk_i);
    nmi_n_i <= 1'b1;
    #1 chk({14'h0, nmi_trap_o, irq_o}, 16'h0001);
    rd_chk(OFS_IRQ_STAT, 16'h0001);
    wr(OFS_IRQ_MASK, 16'h0000);
    tick(1);
    chk({15'h0, irq_o}, 16'h0000);
    wr(OFS_IRQ_STAT, 16'h0001);
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk_i);
      p2_ext[i] <= 1'b0;
      for (k = 0; k < 8 && fast_ext_irq_o === 4'h0; k++) tick(1);
      chk({12'h0, fast_ext_irq_o}, 16'h1 << i);
      @(posedge sys_clk_i);
      p2_ext <= 4'hf;
      rd_chk(OFS_IRQ_STAT, 16'h2 << i);
      wr(OFS_IRQ_STAT, 16'h001f);
    end
  endtask
  task automatic t_power();
    int n;
    @(posedge sys_clk_i);
    power_down_req_i <= 1'b1;
    @(posedge sys_clk_i);
    power_down_req_i <= 1'b0;
    tick(1);
    chk({15'h0, cpu_clk_en_o}, 16'h0000);
    @(posedge sys_clk_i);
    p2_ext[0] <= 1'b0;
    for (n = 0; n < 40 && cpu_clk_en_o !== 1'b1; n++) tick(1);
    chk({15'h0, n >= WAKE && n <= WAKE + 8}, 16'h0001);
    @(posedge sys_clk_i);
    p2_ext <= 4'hf;
    wr(OFS_IRQ_STAT, 16'h001f);
  endtask
  task automatic t_rst(input int src);
    int n;
    wr(OFS_BUS_CFG, 16'h0005);
    @(posedge sys_clk_i);
    ext_rst_n <= (src != 0);
    sw_reset_i <= (src == 1);
    wdt_reset_i <= (src == 2);
    @(posedge sys_clk_i);
    sw_reset_i <= 1'b0;
    wdt_reset_i <= 1'b0;
    #1;
    for (n = 0; n < 8 && reset_in_n_oe_o !== 1'b1; n++) tick(1);
    chk({14'h0, chip_reset_o, reset_indication_n_o}, 16'h0002);
    // Button released once the device pulls, so the pin stays low only by its own drive
    for (n = 1; n < 600; n++) begin
      @(posedge sys_clk_i);
      ext_rst_n <= 1'b1;
      #1;
      if (reset_in_n_oe_o !== 1'b1) break;
    end
    chk(16'(n), 16'(RST_DRIVE_CYCLES));
    chk({15'h0, reset_indication_n_o}, 16'h0000);
    rd_chk(OFS_BUS_CFG, 16'h0000);
    end_init();
    chk({15'h0, reset_indication_n_o}, 16'h0001);
  endtask
  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 8000) begin
      error_cnt++;
      close_out();
    end
  end
  initial begin
    {rst_i, ext_rst_n, nmi_n_i} = 3'h7;
    {reg_wr_i, reg_rd_i, bus_addr_phase_i, bus_data_oe_i, mem_rd, pwm_ch3_out_i} = 6'h00;
    {sw_reset_i, wdt_reset_i, end_of_init_instr_i, power_down_req_i} = 4'h0;
    {reg_addr_i, reg_wdata_i, port5_i, p2_ext} = {8'h00, 16'h0000, 6'h00, 4'hf};
    {bus_addr_i, bus_wdata_i} = {16'h1234, 16'habcd};
    repeat (2) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    tick(2);
    chk({irq_o, cpu_clk_en_o, reset_indication_n_o, reset_in_n_oe_o}, 16'h0004);
    chk(port3_oe_o | bus_data_port_oe_o | bus_address_port_oe_o, 16'h0000);
    rd_chk(8'h7f, 16'h0000);
    end_init();
    rd_chk(OFS_RST_CTRL, 16'h0001);
    t_gpio();
    bus_case(16'h0001, 1'b0, 1'b1, 16'hffff, 16'h00cd, 16'h00ff, 16'hffff);
    bus_case(16'h0005, 1'b0, 1'b1, 16'hffff, 16'habcd, 16'hffff, 16'hffff);
    bus_case(16'h0003, 1'b1, 1'b0, 16'hffff, 16'h1234, 16'hffff, 16'h0000);
    bus_case(16'h0003, 1'b0, 1'b1, 16'h00ff, 16'h00cd, 16'h00ff, 16'h0000);
    bus_case(16'h0007, 1'b0, 1'b1, 16'hffff, 16'habcd, 16'hffff, 16'h0000);
    bus_case(16'h000f, 1'b1, 1'b0, 16'hffff, 16'h1234, 16'hffff, 16'hffff);
    bus_case(16'h0005, 1'b0, 1'b0, 16'hffff, 16'h0000, 16'h0000, 16'hffff);
    @(posedge sys_clk_i);
    mem_rd <= 1'b1;
    tick(3);
    chk(bus_rdata_o, 16'h34cb);
    @(posedge sys_clk_i);
    mem_rd <= 1'b0;
    bus_case(16'h0010, 1'b0, 1'b1, 16'hffff, 16'h0000, 16'h0000, 16'h0000);
    wr(8'h51, 16'h0008);
    @(posedge sys_clk_i);
    pwm_ch3_out_i <= 1'b1;
    tick(1);
    chk({14'h0, port7_oe_o[PWM_BIT], port7_o[PWM_BIT]}, 16'h0003);
    t_irq();
    t_power();
    for (int s = 0; s < 3; s++) t_rst(s);
    close_out();
  end
endmodule
